// *** shared/ftc_pkg.sv ***
// Constants and types for the fault threshold configuration block
package ftc_pkg;
   // Register placement and reset
   localparam logic [7:0] FTC_CFG_OFFSET = 8'h90;
   localparam logic [31:0] FTC_CFG_RESET = 32'h0000_0000;
   localparam logic [31:0] FTC_CFG_WMASK = 32'h7fff_ffff;

   // Field positions
   localparam int FTC_RSVD_BIT = 31;
   localparam int FTC_PEAK_LSB = 27;
   localparam int FTC_CMP_LSB = 23;
   localparam int FTC_ADC_LSB = 19;
   localparam int FTC_RESP_LSB = 15;
   localparam int FTC_FILT_LSB = 11;
   localparam int FTC_WAIT_LSB = 7;
   localparam int FTC_STALL_LSB = 3;
   localparam int FTC_PDTO_BIT = 2;
   localparam int FTC_PDRATE_BIT = 1;
   localparam int FTC_SAT_BIT = 0;
   localparam int FTC_CODE_W = 4;

   // Percentage code table
   localparam logic [6:0] FTC_PCT_STEP = 7'h05;
   localparam logic [3:0] FTC_PCT_MID_FIRST = 4'h6;
   localparam logic [6:0] FTC_PCT_MID_BASE = 7'h28;
   localparam logic [6:0] FTC_PCT_MID_STEP = 7'h0a;
   localparam logic [3:0] FTC_PCT_HIGH_FIRST = 4'h9;
   localparam logic [6:0] FTC_PCT_HIGH_BASE = 7'h41;

   // Lock response codes
   localparam logic [3:0] FTC_RESP_AUTO_FIRST = 4'h4;
   localparam logic [3:0] FTC_RESP_REPORT = 4'h8;
   localparam logic [3:0] FTC_RESP_OFF_FIRST = 4'h9;

   // Timing: 0.1 ms tick from the 100 ns clock
   localparam int FTC_CLK_PERIOD_NS = 100;
   localparam int FTC_TICK_TIME_NS = 100_000;
   localparam int FTC_TICK_CYCLES = FTC_TICK_TIME_NS / FTC_CLK_PERIOD_NS;
   localparam int FTC_TICK_W = 10;
   localparam int FTC_TIMER_W = 15;
   // Retry wait step per code, in 0.1 ms ticks: (code + 1) steps
   localparam logic [14:0] FTC_RETRY_STEP_TICKS = 15'h03e8;
   // Filter time per code, in 0.1 ms ticks
   localparam logic [14:0] FTC_FILT_TICKS [16] = '{
      15'h0000, 15'h0001, 15'h0002, 15'h0005, 15'h000a, 15'h0019,
      15'h0032, 15'h004b, 15'h0064, 15'h00fa, 15'h01f4, 15'h02ee,
      15'h03e8, 15'h07d0, 15'h1388, 15'h2710};

   typedef enum logic [3:0] {
      FTC_IDLE = 4'b0001,
      FTC_LATCHED = 4'b0010,
      FTC_RETRY = 4'b0100,
      FTC_REPORT = 4'b1000
   } ftc_state_t;
endpackage

// *** core/ftc_lock_ctrl.sv ***
// Lock fault filter and response sequencer
module ftc_lock_ctrl
   import ftc_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire logic tick_i,
   input wire logic lock_i,
   input wire logic [3:0] resp_mode_i,
   input wire logic [3:0] filt_code_i,
   input wire logic [3:0] wait_code_i,
   input wire logic [3:0] retry_limit_i,
   input wire logic fault_clear_i,
   output logic fault_active_o,
   output logic gate_tristate_o,
   output logic gate_brake_o
);
   ftc_state_t state_q, state_d;
   logic [14:0] filt_cnt_q;
   logic [14:0] wait_cnt_q;
   logic [3:0] retries_q;
   logic brake_sel_q;
   logic brake_sel;
   logic lock_f;
   logic wait_done;
   logic enabled;
   logic is_auto;

   // Code 0 has a zero count, so the filter passes at once
   assign lock_f = lock_i &&
      (filt_cnt_q >= FTC_FILT_TICKS[filt_code_i]);
   assign wait_done = wait_cnt_q >=
      FTC_RETRY_STEP_TICKS * ({11'h000, wait_code_i} + 15'h0001);
   assign enabled = resp_mode_i < FTC_RESP_OFF_FIRST;
   assign is_auto = resp_mode_i >= FTC_RESP_AUTO_FIRST;

   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i || !lock_i) begin
         filt_cnt_q <= 15'h0000;
      end else if (tick_i && !lock_f) begin
         filt_cnt_q <= filt_cnt_q + 15'h0001;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i || state_q != FTC_RETRY) begin
         wait_cnt_q <= 15'h0000;
      end else if (tick_i && !wait_done) begin
         wait_cnt_q <= wait_cnt_q + 15'h0001;
      end
   end

   always_comb begin
      state_d = state_q;
      case (state_q)
         FTC_IDLE: begin
            if (lock_f && enabled) begin
               if (resp_mode_i == FTC_RESP_REPORT) begin
                  state_d = FTC_REPORT;
               end else if (!is_auto) begin
                  state_d = FTC_LATCHED;
               end else if (retries_q >= retry_limit_i) begin
                  state_d = FTC_LATCHED;
               end else begin
                  state_d = FTC_RETRY;
               end
            end
         end
         FTC_LATCHED: if (fault_clear_i) state_d = FTC_IDLE;
         FTC_RETRY: if (wait_done) state_d = FTC_IDLE;
         FTC_REPORT: if (!lock_f) state_d = FTC_IDLE;
         default: state_d = FTC_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         state_q <= FTC_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // Retries count only auto-cleared faults; a manual clear rearms them
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i || (state_q == FTC_LATCHED && fault_clear_i)) begin
         retries_q <= 4'h0;
      end else if (state_q == FTC_IDLE && state_d == FTC_RETRY) begin
         retries_q <= retries_q + 4'h1;
      end
   end

   // Action is frozen at entry so a mode rewrite cannot flip the bridge
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         brake_sel_q <= 1'b0;
      end else if (state_q == FTC_IDLE) begin
         brake_sel_q <= resp_mode_i[1];
      end
   end

   // Live mode while idle, so the entry edge never sees a stale copy
   assign brake_sel = (state_q == FTC_IDLE) ? resp_mode_i[1] : brake_sel_q;

   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         fault_active_o <= 1'b0;
         gate_tristate_o <= 1'b0;
         gate_brake_o <= 1'b0;
      end else begin
         fault_active_o <= state_d != FTC_IDLE;
         gate_tristate_o <= (state_d == FTC_LATCHED ||
            state_d == FTC_RETRY) && !brake_sel;
         gate_brake_o <= (state_d == FTC_LATCHED ||
            state_d == FTC_RETRY) && brake_sel;
      end
   end

   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);

   a_latch_hold: assert property (
      state_q == FTC_LATCHED && !fault_clear_i |=>
      state_q == FTC_LATCHED && fault_active_o)
      else $error("latched fault did not hold");
   a_retry_limit: assert property (
      state_q == FTC_IDLE && lock_f && is_auto && enabled &&
      resp_mode_i != FTC_RESP_REPORT && retries_q >= retry_limit_i
      |=> state_q == FTC_LATCHED)
      else $error("retry limit did not latch fault");
   a_report_only: assert property (
      state_q == FTC_REPORT |=> !gate_tristate_o && !gate_brake_o)
      else $error("report mode acted on gate driver");
   a_lock_disabled: assert property (
      state_q == FTC_IDLE && !enabled |=> state_q == FTC_IDLE)
      else $error("disabled mode reacted to lock");
   a_filter_none: assert property (
      state_q == FTC_IDLE && lock_i && filt_code_i == 4'h0 && enabled
      |=> state_q != FTC_IDLE)
      else $error("unfiltered lock not taken at once");
   c_retry: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      state_q == FTC_IDLE ##1 state_q == FTC_RETRY);
   c_latch: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      state_q == FTC_LATCHED && fault_clear_i);
endmodule

// *** core/ftc_top.sv ***
// Fault threshold configuration register with lock fault handling
module ftc_top
   import ftc_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   output logic [31:0] reg_rdata_o,
   input wire logic lock_cond_i,
   input wire logic [3:0] retry_count_limit_i,
   input wire logic fault_clear_i,
   output logic [6:0] peak_limit_pct_o,
   output logic [6:0] comparator_lock_threshold_pct_o,
   output logic [6:0] adc_lock_threshold_pct_o,
   output logic [3:0] retry_wait_time_o,
   output logic [3:0] stall_response_select_o,
   output logic pulse_detect_timeout_enable_o,
   output logic pulse_detect_rate_enable_o,
   output logic saturation_flag_enable_o,
   output logic fault_indicator_pin_b_o,
   output logic gate_tristate_o,
   output logic gate_brake_o
);
   localparam int PCT_LSB [3] = '{FTC_PEAK_LSB, FTC_CMP_LSB, FTC_ADC_LSB};

   logic [31:0] cfg_q;
   logic [6:0] pct_q [3];
   logic [FTC_TICK_W-1:0] tick_cnt_q;
   logic tick;
   logic sync1_q, sync2_q, sync3_q;
   logic lock_q;
   logic cfg_hit;
   logic fault_active;

   assign cfg_hit = reg_addr_i == FTC_CFG_OFFSET;

   function automatic logic [6:0] ftc_pct(input logic [3:0] c);
      logic [6:0] v;
      v = {3'h0, c};
      if (c < FTC_PCT_MID_FIRST) begin
         ftc_pct = FTC_PCT_STEP * (v + 7'h01);
      end else if (c < FTC_PCT_HIGH_FIRST) begin
         ftc_pct = FTC_PCT_MID_BASE +
            FTC_PCT_MID_STEP * (v - {3'h0, FTC_PCT_MID_FIRST});
      end else begin
         ftc_pct = FTC_PCT_HIGH_BASE +
            FTC_PCT_STEP * (v - {3'h0, FTC_PCT_HIGH_FIRST});
      end
   endfunction

   // Configuration storage
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         cfg_q <= FTC_CFG_RESET;
      end else if (reg_wr_i && cfg_hit) begin
         cfg_q <= reg_wdata_i & FTC_CFG_WMASK;
      end
   end

   // Read port; unmapped offsets read as zero
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         reg_rdata_o <= 32'h0000_0000;
      end else if (reg_rd_i) begin
         reg_rdata_o <= cfg_hit ? cfg_q : 32'h0000_0000;
      end
   end

   // Threshold decode, one cycle behind the register
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_pct
         always_ff @(posedge sys_clk_i) begin
            if (!rst_b_i) begin
               pct_q[gi] <= ftc_pct(4'h0);
            end else begin
               pct_q[gi] <= ftc_pct(
                  cfg_q[PCT_LSB[gi] +: FTC_CODE_W]);
            end
         end
      end
   endgenerate

   assign peak_limit_pct_o = pct_q[0];
   assign comparator_lock_threshold_pct_o = pct_q[1];
   assign adc_lock_threshold_pct_o = pct_q[2];

   assign retry_wait_time_o = cfg_q[FTC_WAIT_LSB +: FTC_CODE_W];
   assign stall_response_select_o =
      cfg_q[FTC_STALL_LSB +: FTC_CODE_W];
   assign pulse_detect_timeout_enable_o = cfg_q[FTC_PDTO_BIT];
   assign pulse_detect_rate_enable_o = cfg_q[FTC_PDRATE_BIT];
   assign saturation_flag_enable_o = cfg_q[FTC_SAT_BIT];

   // 0.1 ms time base; all filter and retry timers count these ticks
   assign tick = tick_cnt_q == FTC_TICK_W'(FTC_TICK_CYCLES - 1);

   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i || tick) begin
         tick_cnt_q <= '0;
      end else begin
         tick_cnt_q <= tick_cnt_q + 1'b1;
      end
   end

   // Lock condition arrives from a pin; a change counts when stages agree
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         sync3_q <= 1'b0;
      end else begin
         sync1_q <= lock_cond_i;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         lock_q <= 1'b0;
      end else if (sync2_q == sync3_q) begin
         lock_q <= sync3_q;
      end
   end

   ftc_lock_ctrl u_lock (
      .sys_clk_i(sys_clk_i),
      .rst_b_i(rst_b_i),
      .tick_i(tick),
      .lock_i(lock_q),
      .resp_mode_i(cfg_q[FTC_RESP_LSB +: FTC_CODE_W]),
      .filt_code_i(cfg_q[FTC_FILT_LSB +: FTC_CODE_W]),
      .wait_code_i(cfg_q[FTC_WAIT_LSB +: FTC_CODE_W]),
      .retry_limit_i(retry_count_limit_i),
      .fault_clear_i(fault_clear_i),
      .fault_active_o(fault_active),
      .gate_tristate_o(gate_tristate_o),
      .gate_brake_o(gate_brake_o)
   );

   // Pin is active low, so it idles high out of reset
   assign fault_indicator_pin_b_o = !fault_active;

   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);

   a_reset_clear: assert property (
      $rose(rst_b_i) |-> cfg_q == FTC_CFG_RESET && reg_rdata_o == 32'h0)
      else $error("register not cleared by reset");
   a_write_store: assert property (
      reg_wr_i && cfg_hit |=> cfg_q == ($past(reg_wdata_i) & FTC_CFG_WMASK))
      else $error("write not stored");
   a_read_back: assert property (
      reg_rd_i && !reg_wr_i ##1 1'b1 |-> reg_rdata_o ==
      ($past(cfg_hit) ? $past(cfg_q) : 32'h0))
      else $error("read data wrong");
   a_rsvd_zero: assert property (
      reg_rd_i |=> !reg_rdata_o[FTC_RSVD_BIT] && !cfg_q[FTC_RSVD_BIT])
      else $error("reserved bit not zero");

   // Every percentage field is checked over all three code bands
   a_peak_low: assert property (
      cfg_q[30:27] < 4'h6 |=>
      peak_limit_pct_o == 7'h05 * (7'($past(cfg_q[30:27])) + 7'h01))
      else $error("peak limit low codes wrong");
   a_peak_mid: assert property (
      cfg_q[30:27] inside {4'h6, 4'h7, 4'h8} |=>
      peak_limit_pct_o ==
      7'h28 + 7'h0a * (7'($past(cfg_q[30:27])) - 7'h06))
      else $error("peak limit mid codes wrong");
   a_peak_high: assert property (
      cfg_q[30:27] >= 4'h9 |=>
      peak_limit_pct_o ==
      7'h41 + 7'h05 * (7'($past(cfg_q[30:27])) - 7'h09))
      else $error("peak limit high codes wrong");
   a_cmp_low: assert property (
      cfg_q[26:23] < 4'h6 |=>
      comparator_lock_threshold_pct_o ==
      7'h05 * (7'($past(cfg_q[26:23])) + 7'h01))
      else $error("comparator threshold low codes wrong");
   a_cmp_mid: assert property (
      cfg_q[26:23] inside {4'h6, 4'h7, 4'h8} |=>
      comparator_lock_threshold_pct_o ==
      7'h28 + 7'h0a * (7'($past(cfg_q[26:23])) - 7'h06))
      else $error("comparator threshold mid codes wrong");
   a_cmp_high: assert property (
      cfg_q[26:23] >= 4'h9 |=>
      comparator_lock_threshold_pct_o ==
      7'h41 + 7'h05 * (7'($past(cfg_q[26:23])) - 7'h09))
      else $error("comparator threshold high codes wrong");
   a_adc_low: assert property (
      cfg_q[22:19] < 4'h6 |=>
      adc_lock_threshold_pct_o ==
      7'h05 * (7'($past(cfg_q[22:19])) + 7'h01))
      else $error("adc threshold low codes wrong");
   a_adc_mid: assert property (
      cfg_q[22:19] inside {4'h6, 4'h7, 4'h8} |=>
      adc_lock_threshold_pct_o ==
      7'h28 + 7'h0a * (7'($past(cfg_q[22:19])) - 7'h06))
      else $error("adc threshold mid codes wrong");
   a_adc_high: assert property (
      cfg_q[22:19] >= 4'h9 |=> adc_lock_threshold_pct_o ==
      7'h41 + 7'h05 * (7'($past(cfg_q[22:19])) - 7'h09))
      else $error("adc threshold high codes wrong");
   a_plain_store: assert property (
      reg_wr_i && cfg_hit |=> stall_response_select_o ==
      $past(reg_wdata_i[6:3]) && saturation_flag_enable_o ==
      $past(reg_wdata_i[0]))
      else $error("plain fields not stored");
   c_cfg_write: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      reg_wr_i && cfg_hit ##1 reg_rd_i && cfg_hit);
   c_fault_pin: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      $fell(fault_indicator_pin_b_o));
endmodule

// *** bench/ftc_top_tb.sv ***
// Self-checking bench for the fault threshold configuration block
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; \
   $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end

module ftc_top_tb
   import ftc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic sys_clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic [7:0] reg_addr_i = 8'h00;
   logic [31:0] reg_wdata_i = 32'h0;
   logic [31:0] reg_rdata_o;
   logic lock_cond_i = 1'b0;
   logic [3:0] retry_count_limit_i = 4'h0;
   logic fault_clear_i = 1'b0;
   logic [6:0] peak_pct, cmp_pct, adc_pct;
   logic [3:0] retry_wait_time_o, stall_response_select_o;
   logic pd_to_en, pd_rate_en, sat_en;
   logic fault_indicator_pin_b_o, gate_tristate_o, gate_brake_o;
   int error_cnt = 0;
   int checks = 0;

   ftc_top u_ftc_top (
      .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .reg_wr_i(reg_wr_i),
      .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
      .lock_cond_i(lock_cond_i), .retry_count_limit_i(retry_count_limit_i),
      .fault_clear_i(fault_clear_i), .peak_limit_pct_o(peak_pct),
      .comparator_lock_threshold_pct_o(cmp_pct),
      .adc_lock_threshold_pct_o(adc_pct),
      .retry_wait_time_o(retry_wait_time_o),
      .stall_response_select_o(stall_response_select_o),
      .pulse_detect_timeout_enable_o(pd_to_en),
      .pulse_detect_rate_enable_o(pd_rate_en),
      .saturation_flag_enable_o(sat_en),
      .fault_indicator_pin_b_o(fault_indicator_pin_b_o),
      .gate_tristate_o(gate_tristate_o), .gate_brake_o(gate_brake_o));

   initial begin
      forever #50 sys_clk_i = ~sys_clk_i;
   end

   // Inputs always move a fixed 10 ns after the rising edge
   task automatic step(input int n);
      repeat (n) @(posedge sys_clk_i);
      #10;
   endtask

   task automatic give_verdict();
      $display("checks=%0d errors=%0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      reg_wr_i = 1'b1;
      reg_addr_i = a;
      reg_wdata_i = d;
      step(1);
      reg_wr_i = 1'b0;
   endtask

   task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
      reg_rd_i = 1'b1;
      reg_addr_i = a;
      step(1);
      reg_rd_i = 1'b0;
      d = reg_rdata_o;
   endtask

   function automatic logic [6:0] pct(input logic [3:0] c);
      if (c < 4'h6) return 7'(5 + 5 * c);
      else if (c < 4'h9) return 7'(40 + 10 * (c - 6));
      else return 7'(65 + 5 * (c - 9));
   endfunction

   task automatic wait_pin(input logic lvl, input int lim);
      int n;
      n = 0;
      while (fault_indicator_pin_b_o !== lvl && n < lim) begin
         step(1);
         n++;
      end
      if (n >= lim) begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time,
            fault_indicator_pin_b_o, lvl);
         give_verdict();
      end
   endtask

   // Latching response: fault holds after lock drops, until cleared
   task automatic latch_case(input logic [3:0] m, input logic brk);
      reg_write(FTC_CFG_OFFSET, {13'h0, m, 15'h0});
      lock_cond_i = 1'b1;
      wait_pin(1'b0, 20);
      `CHK(gate_tristate_o, ~brk)
      `CHK(gate_brake_o, brk)
      lock_cond_i = 1'b0;
      step(10);
      `CHK(fault_indicator_pin_b_o, 1'b0)
      fault_clear_i = 1'b1;
      step(1);
      fault_clear_i = 1'b0;
      step(2);
      `CHK({fault_indicator_pin_b_o, gate_tristate_o, gate_brake_o},
         3'b100)
   endtask

   initial begin
      logic [31:0] rd;
      logic [3:0] c;
      step(12);
      rst_b_i = 1'b1;
      reg_read(FTC_CFG_OFFSET, rd);
      `CHK(rd, FTC_CFG_RESET)
      `CHK({peak_pct, cmp_pct, adc_pct}, {3{7'h05}})
      `CHK(fault_indicator_pin_b_o, 1'b1)
      $display("test reset done");

      reg_write(FTC_CFG_OFFSET, 32'hffff_ffff);
      reg_read(FTC_CFG_OFFSET, rd);
      `CHK(rd, 32'h7fff_ffff)
      `CHK({retry_wait_time_o, stall_response_select_o}, 8'hff)
      `CHK({pd_to_en, pd_rate_en, sat_en}, 3'b111)
      reg_write(FTC_CFG_OFFSET, 32'h0000_0355);
      step(1);
      `CHK({retry_wait_time_o, stall_response_select_o}, 8'h6a)
      `CHK({pd_to_en, pd_rate_en, sat_en}, 3'b101)
      reg_write(8'h92, 32'h1234_5678);
      reg_read(FTC_CFG_OFFSET, rd);
      `CHK(rd, 32'h0000_0355)
      // An edge between reads, so the strobe never falls and rises at once
      step(1);
      reg_read(8'h92, rd);
      `CHK(rd, 32'h0)
      $display("test access done");

      for (int i = 0; i < 16; i++) begin
         c = 4'(i);
         reg_write(FTC_CFG_OFFSET, {1'b0, c, ~c, c + 4'h5, 19'h0});
         step(2);
         `CHK(peak_pct, pct(c))
         `CHK(cmp_pct, pct(~c))
         `CHK(adc_pct, pct(c + 4'h5))
      end
      $display("test percent done");

      // Limit 0 makes the retrying codes latch on the first lock
      for (int i = 0; i < 8; i++) begin
         latch_case(4'(i), i[1]);
      end
      $display("test latch modes done");

      reg_write(FTC_CFG_OFFSET, {13'h0, 4'h8, 15'h0});
      lock_cond_i = 1'b1;
      wait_pin(1'b0, 20);
      `CHK({gate_tristate_o, gate_brake_o}, 2'b00)
      lock_cond_i = 1'b0;
      wait_pin(1'b1, 20);
      `CHK(fault_indicator_pin_b_o, 1'b1)
      for (int i = 9; i < 16; i++) begin
         reg_write(FTC_CFG_OFFSET, {13'h0, 4'(i), 15'h0});
         lock_cond_i = 1'b1;
         step(20);
         `CHK({fault_indicator_pin_b_o, gate_tristate_o}, 2'b10)
         lock_cond_i = 1'b0;
         step(5);
      end
      $display("test report and off done");

      // Filter code 4 is ten ticks of 1000 cycles, one tick may be lost
      reg_write(FTC_CFG_OFFSET, {17'h0, 4'h4, 11'h0});
      lock_cond_i = 1'b1;
      step(8900);
      `CHK(fault_indicator_pin_b_o, 1'b1)
      wait_pin(1'b0, 1300);
      `CHK(gate_tristate_o, 1'b1)
      // Lock must be through the synchroniser before the clear
      lock_cond_i = 1'b0;
      step(6);
      `CHK(fault_indicator_pin_b_o, 1'b0)
      fault_clear_i = 1'b1;
      step(1);
      fault_clear_i = 1'b0;
      wait_pin(1'b1, 5);
      step(3);
      `CHK(fault_indicator_pin_b_o, 1'b1)
      $display("test filter done");

      // Retry wait far outlasts the run, so a reset ends it early
      retry_count_limit_i = 4'h1;
      reg_write(FTC_CFG_OFFSET, {13'h0, 4'h4, 15'h0});
      lock_cond_i = 1'b1;
      wait_pin(1'b0, 20);
      `CHK({gate_tristate_o, gate_brake_o}, 2'b10)
      lock_cond_i = 1'b0;
      step(20);
      `CHK(fault_indicator_pin_b_o, 1'b0)
      fault_clear_i = 1'b1;
      step(1);
      fault_clear_i = 1'b0;
      step(2);
      `CHK(fault_indicator_pin_b_o, 1'b0)
      rst_b_i = 1'b0;
      step(2);
      rst_b_i = 1'b1;
      reg_read(FTC_CFG_OFFSET, rd);
      `CHK(rd, FTC_CFG_RESET)
      `CHK({fault_indicator_pin_b_o, gate_tristate_o, gate_brake_o},
         3'b100)
      $display("test retry and reset done");
      give_verdict();
   end
endmodule
